// file: hw/mps_pkg.sv
// shared constants and types for the motion program sequencer
package mps_pkg;
   localparam int SET_W      = 8;    // 256 set entries
   localparam int SET_N      = 256;
   localparam int POS_W      = 32;
   localparam int SPD_W      = 16;
   localparam int DIN_N      = 8;
   localparam int DIN_SEL_W  = 3;
   localparam int DOUT_N     = 2;
   localparam int ADDR_W     = 12;

   // ------------------------------------------------------------
   // register map (word offsets on the plain port)
   // ------------------------------------------------------------
   localparam logic [11:0] REG_CTRL      = 12'h000;
   localparam logic [11:0] REG_ENTRY     = 12'h001;
   localparam logic [11:0] REG_DINMAP    = 12'h002;
   localparam logic [11:0] REG_DINMAP2   = 12'h003;
   localparam logic [11:0] REG_JOGSPD    = 12'h004;
   localparam logic [11:0] REG_JOGACC    = 12'h005;
   localparam logic [11:0] REG_DOUTSEL   = 12'h006;
   localparam logic [11:0] REG_TOL       = 12'h007;
   localparam logic [11:0] REG_TRIGPOS   = 12'h008;
   localparam logic [11:0] REG_STATUS    = 12'h009;
   localparam logic [11:0] REG_START     = 12'h00a;
   localparam logic [11:0] REG_ACTPOS    = 12'h00b;
   localparam logic [11:0] REG_TGTPOS    = 12'h00c;
   localparam logic [11:0] SET_TGT_BASE  = 12'h400;
   localparam logic [11:0] SET_CFG_BASE  = 12'h800;
   localparam logic [11:0] SET_REM_BASE  = 12'hc00;
   localparam logic [1:0]  SET_AREA_TGT  = 2'h1;
   localparam logic [1:0]  SET_AREA_CFG  = 2'h2;
   localparam logic [1:0]  SET_AREA_REM  = 2'h3;

   // ctrl bits
   localparam int CTRL_PROG_EN = 0;
   localparam int CTRL_JOG_EN  = 1;
   localparam int CTRL_HOMED   = 2;

   // set config word fields
   localparam int CFG_SUCC1_LSB = 0;
   localparam int CFG_SUCC2_LSB = 8;
   localparam int CFG_REACT_LSB = 16;
   localparam int CFG_REACT_W   = 3;
   localparam int CFG_IGNSTOP   = 19;
   localparam int CFG_MSG0_LSB  = 20;
   localparam int CFG_MSG1_LSB  = 22;

   // default input lines: branch a on line two, branch b on line three
   localparam logic [2:0] DEF_SEL_BRA   = 3'h2;
   localparam logic [2:0] DEF_SEL_BRB   = 3'h3;
   localparam logic [2:0] DEF_SEL_ENTA  = 3'h0;
   localparam logic [2:0] DEF_SEL_ENTB  = 3'h1;
   localparam logic [2:0] DEF_SEL_STOP  = 3'h4;
   localparam logic [2:0] DEF_SEL_COMB  = 3'h5;
   localparam logic [2:0] DEF_SEL_JOGP  = 3'h6;
   localparam logic [2:0] DEF_SEL_JOGN  = 3'h7;

   typedef enum logic [2:0] {
      REACT_NOW      = 3'h0,
      REACT_IGNORE   = 3'h1,
      REACT_AT_TGT   = 3'h2,
      REACT_LATCH    = 3'h3,
      REACT_FINAL    = 3'h4
   } react_t;

   typedef enum logic [1:0] {
      MSG_TGT   = 2'h0,
      MSG_REM   = 2'h1,
      MSG_ACT   = 2'h2,
      MSG_OFF   = 2'h3
   } step_msg_t;

   typedef enum logic [2:0] {
      OUT_SP_TGT  = 3'h0,
      OUT_ACT_TGT = 3'h1,
      OUT_REM     = 3'h2,
      OUT_HOMED   = 3'h3,
      OUT_TRIG    = 3'h4,
      OUT_STEP    = 3'h5
   } out_opt_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_MOVE = 2'b01,
      ST_JOG  = 2'b11
   } seq_state_t;
endpackage

// file: hw/mps_din_sync.sv
// two-stage synchroniser and rise detector for the digital inputs
`timescale 1ns/1ps
module mps_din_sync #(
   parameter int N = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [N-1:0] din,
   output logic      [N-1:0] lvl,
   output logic      [N-1:0] rise
);
   logic [N-1:0] s1_r;
   logic [N-1:0] s2_r;
   logic [N-1:0] s3_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   assign lvl  = s2_r;
   assign rise = s2_r & ~s3_r;
endmodule // mps_din_sync

// file: hw/mps_msg_out.sv
// positioning message selection for one digital output
`timescale 1ns/1ps
module mps_msg_out
   import mps_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [2:0]       opt,
   input  wire logic [1:0]       step_msg,
   input  wire logic             sp_eq_tgt,
   input  wire logic             act_in_tol,
   input  wire logic             rem_hit,
   input  wire logic             homed,
   input  wire logic             trig_hit,
   input  wire logic             set_active,
   output logic                  dout_r
);
   logic step_val;

   always_comb begin
      case (step_msg)
         MSG_TGT: step_val = act_in_tol;
         MSG_REM: step_val = rem_hit;
         MSG_ACT: step_val = set_active;
         default: step_val = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         dout_r <= 1'b0;
      end else begin
         case (opt)
            OUT_SP_TGT:  dout_r <= sp_eq_tgt;
            OUT_ACT_TGT: dout_r <= act_in_tol;
            OUT_REM:     dout_r <= rem_hit;
            OUT_HOMED:   dout_r <= homed;
            OUT_TRIG:    dout_r <= trig_hit;
            OUT_STEP:    dout_r <= step_val;
            default:     dout_r <= 1'b0;
         endcase
      end
   end
endmodule // mps_msg_out

// file: hw/mps_sequencer.sv
// motion program sequencer: set table, branching, stop, jog, output messages
`timescale 1ns/1ps
module mps_sequencer
   import mps_pkg::*;
(
   input  wire logic                       CORE_CLK,
   input  wire logic                       RESET,
   input  wire logic [mps_pkg::ADDR_W-1:0] ADDR,
   input  wire logic [31:0]                WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output logic      [31:0]                RDATA,
   input  wire logic [mps_pkg::DIN_N-1:0]  DIN,
   input  wire logic [mps_pkg::POS_W-1:0]  ACT_POS,
   input  wire logic [mps_pkg::POS_W-1:0]  SP_POS,
   input  wire logic                       TARGET_DONE,
   output logic                            MOVE_START,
   output logic      [mps_pkg::POS_W-1:0]  MOVE_TARGET,
   output logic      [mps_pkg::SET_W-1:0]  CUR_SET,
   output logic                            PROG_RUN,
   output logic                            JOG_POS,
   output logic                            JOG_NEG,
   output logic      [mps_pkg::SPD_W-1:0]  JOG_SPEED,
   output logic      [mps_pkg::SPD_W-1:0]  JOG_ACCEL,
   output logic      [mps_pkg::DOUT_N-1:0] DOUT
);
   import mps_pkg::*;

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   logic [POS_W-1:0] tgt_mem [SET_N];
   logic [31:0]      cfg_mem [SET_N];
   logic [POS_W-1:0] rem_mem [SET_N];

   logic [2:0]       ctrl_r;
   logic [SET_W-1:0] entry_a_r;
   logic [SET_W-1:0] entry_b_r;
   logic [23:0]      dinmap_r;
   logic [31:0]      jogspd_r;
   logic [31:0]      jogacc_r;
   logic [5:0]       doutsel_r;
   logic [POS_W-1:0] tol_r;
   logic [POS_W-1:0] trigpos_r;
   logic [SET_W:0]   direct_r;          // bit8 marks a pending direct start

   // ------------------------------------------------------------
   // inputs
   // ------------------------------------------------------------
   logic [DIN_N-1:0] din_lvl;
   logic [DIN_N-1:0] din_rise;

   mps_din_sync #(.N(DIN_N)) u_sync (
      .clk  (CORE_CLK),
      .rst  (RESET),
      .din  (DIN),
      .lvl  (din_lvl),
      .rise (din_rise)
   );

   logic lv_bra, lv_brb, lv_stop, lv_jogp, lv_jogn;
   logic rs_bra, rs_brb, rs_enta, rs_entb, rs_stop, rs_comb;

   always_comb begin
      lv_bra  = din_lvl[dinmap_r[2:0]];
      lv_brb  = din_lvl[dinmap_r[5:3]];
      rs_bra  = din_rise[dinmap_r[2:0]];
      rs_brb  = din_rise[dinmap_r[5:3]];
      rs_enta = din_rise[dinmap_r[8:6]];
      rs_entb = din_rise[dinmap_r[11:9]];
      lv_stop = din_lvl[dinmap_r[14:12]];
      rs_stop = din_rise[dinmap_r[14:12]];
      rs_comb = din_rise[dinmap_r[17:15]] & dinmap_r[23];
      lv_jogp = din_lvl[dinmap_r[20:18]];
      lv_jogn = din_lvl[dinmap_r[23:21]] & 1'b1;
   end

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   logic [1:0]       area;
   logic [SET_W-1:0] set_idx;
   assign area    = ADDR[11:10];
   assign set_idx = ADDR[SET_W-1:0];

   always_ff @(posedge CORE_CLK) begin
      if (WR && area == SET_AREA_TGT)
         tgt_mem[set_idx] <= WDATA;
      if (WR && area == SET_AREA_CFG)
         cfg_mem[set_idx] <= WDATA;
      if (WR && area == SET_AREA_REM)
         rem_mem[set_idx] <= WDATA;
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         ctrl_r    <= 3'h0;
         entry_a_r <= 8'h00;
         entry_b_r <= 8'h00;
         dinmap_r  <= {DEF_SEL_JOGN, DEF_SEL_JOGP, DEF_SEL_COMB, DEF_SEL_STOP,
                       DEF_SEL_ENTB, DEF_SEL_ENTA, DEF_SEL_BRB, DEF_SEL_BRA};
         jogspd_r  <= 32'h0;
         jogacc_r  <= 32'h0;
         doutsel_r <= 6'h0;
         tol_r     <= 32'h0;
         trigpos_r <= 32'h0;
      end else if (WR) begin
         case (ADDR)
            REG_CTRL:    ctrl_r    <= WDATA[2:0];
            REG_ENTRY:   {entry_b_r, entry_a_r} <= WDATA[15:0];
            REG_DINMAP:  dinmap_r  <= WDATA[23:0];
            REG_JOGSPD:  jogspd_r  <= WDATA;
            REG_JOGACC:  jogacc_r  <= WDATA;
            REG_DOUTSEL: doutsel_r <= WDATA[5:0];
            REG_TOL:     tol_r     <= WDATA;
            REG_TRIGPOS: trigpos_r <= WDATA;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   seq_state_t       state_r;
   logic [SET_W-1:0] cur_r;
   logic [31:0]      cfg_cur;
   react_t           react;
   logic             stop_pend_r;
   logic [1:0]       latch_r;        // 01 = a, 10 = b
   logic             start_r;
   logic [SET_W-1:0] start_set_r;
   logic             go;
   logic [SET_W-1:0] go_set;

   assign cfg_cur = cfg_mem[cur_r];
   assign react   = react_t'(cfg_cur[CFG_REACT_LSB +: CFG_REACT_W]);

   always_ff @(posedge CORE_CLK) begin
      if (RESET)
         direct_r <= 9'h000;
      else if (WR && ADDR == REG_START)
         direct_r <= {1'b1, WDATA[SET_W-1:0]};
      else
         direct_r <= 9'h000;
   end

   always_comb begin
      go     = 1'b1;
      go_set = entry_a_r;
      if (direct_r[SET_W])
         go_set = direct_r[SET_W-1:0];
      else if (rs_enta || (rs_comb && state_r == ST_IDLE))
         go_set = entry_a_r;
      else if (rs_entb)
         go_set = entry_b_r;
      else
         go = 1'b0;
   end

   // branch pick with first input preferred
   logic       br_any;
   logic [SET_W-1:0] br_set;
   always_comb begin
      br_any = lv_bra | lv_brb;
      br_set = lv_bra ? cfg_cur[CFG_SUCC1_LSB +: SET_W]
                      : cfg_cur[CFG_SUCC2_LSB +: SET_W];
   end

   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         state_r     <= ST_IDLE;
         cur_r       <= 8'h00;
         stop_pend_r <= 1'b0;
         latch_r     <= 2'h0;
         start_r     <= 1'b0;
      end else begin
         start_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               stop_pend_r <= 1'b0;
               latch_r     <= 2'h0;
               if (go) begin
                  cur_r   <= go_set;
                  start_r <= 1'b1;
                  state_r <= ST_MOVE;
               end else if (ctrl_r[CTRL_JOG_EN] && (lv_jogp || lv_jogn)) begin
                  state_r <= ST_JOG;
               end
            end
            ST_MOVE: begin
               if (rs_bra)
                  latch_r <= 2'h1;
               else if (rs_brb)
                  latch_r <= 2'h2;
               if ((lv_stop || rs_comb) && !cfg_cur[CFG_IGNSTOP]) begin
                  state_r <= ST_IDLE;
               end else if (lv_stop && cfg_cur[CFG_IGNSTOP]) begin
                  stop_pend_r <= 1'b1;
               end
               if (!((lv_stop || rs_comb) && !cfg_cur[CFG_IGNSTOP])) begin
                  if (ctrl_r[CTRL_PROG_EN] && react == REACT_NOW && br_any) begin
                     cur_r   <= br_set;
                     start_r <= 1'b1;
                     latch_r <= 2'h0;
                  // done still shows the previous set until the core sees the start pulse
                  end else if (TARGET_DONE && !start_r && !MOVE_START) begin
                     latch_r <= 2'h0;
                     if (!ctrl_r[CTRL_PROG_EN] || react == REACT_FINAL) begin
                        state_r <= ST_IDLE;
                     end else if (stop_pend_r && !cfg_cur[CFG_IGNSTOP]) begin
                        state_r <= ST_IDLE;
                     end else begin
                        start_r <= 1'b1;
                        if (react == REACT_AT_TGT && br_any)
                           cur_r <= br_set;
                        else if (react == REACT_LATCH && latch_r == 2'h2)
                           cur_r <= cfg_cur[CFG_SUCC2_LSB +: SET_W];
                        else
                           cur_r <= cfg_cur[CFG_SUCC1_LSB +: SET_W];
                        if (!cfg_cur[CFG_IGNSTOP])
                           stop_pend_r <= 1'b0;
                     end
                  end
               end
            end
            ST_JOG: begin
               if (!ctrl_r[CTRL_JOG_EN] || !(lv_jogp || lv_jogn))
                  state_r <= ST_IDLE;
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // outputs to the motion core
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         MOVE_START  <= 1'b0;
         MOVE_TARGET <= 32'h0;
         CUR_SET     <= 8'h00;
         PROG_RUN    <= 1'b0;
         JOG_POS     <= 1'b0;
         JOG_NEG     <= 1'b0;
         JOG_SPEED   <= 16'h0;
         JOG_ACCEL   <= 16'h0;
      end else begin
         MOVE_START  <= start_r;
         MOVE_TARGET <= tgt_mem[cur_r];
         CUR_SET     <= cur_r;
         PROG_RUN    <= (state_r == ST_MOVE);
         JOG_POS     <= (state_r == ST_JOG) && lv_jogp && ctrl_r[CTRL_JOG_EN];
         JOG_NEG     <= (state_r == ST_JOG) && lv_jogn && !lv_jogp
                        && ctrl_r[CTRL_JOG_EN];
         JOG_SPEED   <= lv_jogp ? jogspd_r[15:0] : jogspd_r[31:16];
         JOG_ACCEL   <= lv_jogp ? jogacc_r[15:0] : jogacc_r[31:16];
      end
   end

   // ------------------------------------------------------------
   // positioning messages
   // ------------------------------------------------------------
   logic [POS_W-1:0] tgt_cur;
   logic [POS_W-1:0] diff;
   logic [POS_W-1:0] rem_cur;
   logic             in_tol;
   logic             rem_hit;
   logic             trig_hit;
   logic             moving;

   assign tgt_cur  = tgt_mem[cur_r];
   assign diff     = (ACT_POS > tgt_cur) ? ACT_POS - tgt_cur : tgt_cur - ACT_POS;
   assign in_tol   = (diff <= tol_r);
   assign moving   = (state_r == ST_MOVE);
   assign rem_cur  = rem_mem[cur_r];
   assign rem_hit  = moving && (diff <= rem_cur);
   assign trig_hit = (ACT_POS == trigpos_r);

   genvar g;
   generate
      for (g = 0; g < DOUT_N; g++) begin : g_out
         mps_msg_out u_msg (
            .clk        (CORE_CLK),
            .rst        (RESET),
            .opt        (doutsel_r[3*g +: 3]),
            .step_msg   (cfg_cur[CFG_MSG0_LSB + 2*g +: 2]),
            .sp_eq_tgt  (SP_POS == tgt_cur),
            .act_in_tol (in_tol),
            .rem_hit    (rem_hit),
            .homed      (ctrl_r[CTRL_HOMED]),
            .trig_hit   (trig_hit),
            .set_active (moving),
            .dout_r     (DOUT[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge CORE_CLK) begin
      if (RESET) begin
         RDATA <= 32'h0;
      end else if (RD) begin
         case (area)
            SET_AREA_TGT: RDATA <= tgt_mem[set_idx];
            SET_AREA_CFG: RDATA <= cfg_mem[set_idx];
            SET_AREA_REM: RDATA <= rem_mem[set_idx];
            default: begin
               case (ADDR)
                  REG_CTRL:    RDATA <= {29'h0, ctrl_r};
                  REG_ENTRY:   RDATA <= {16'h0, entry_b_r, entry_a_r};
                  REG_DINMAP:  RDATA <= {8'h0, dinmap_r};
                  REG_JOGSPD:  RDATA <= jogspd_r;
                  REG_JOGACC:  RDATA <= jogacc_r;
                  REG_DOUTSEL: RDATA <= {26'h0, doutsel_r};
                  REG_TOL:     RDATA <= tol_r;
                  REG_TRIGPOS: RDATA <= trigpos_r;
                  REG_STATUS:  RDATA <= {18'h0, latch_r, stop_pend_r, state_r, 1'b0, cur_r};
                  REG_ACTPOS:  RDATA <= ACT_POS;
                  REG_TGTPOS:  RDATA <= tgt_cur;
                  default:     RDATA <= 32'h0;
               endcase
            end
         endcase
      end else begin
         RDATA <= 32'h0;
      end
   end
endmodule // mps_sequencer

// file: bench/mps_seq_checker.sv
// port-level assertions for the motion program sequencer
`timescale 1ns/1ps
module mps_seq_checker (
   input wire logic                       CORE_CLK,
   input wire logic                       RESET,
   input wire logic [mps_pkg::ADDR_W-1:0] ADDR,
   input wire logic [31:0]                WDATA,
   input wire logic                       WR,
   input wire logic                       RD,
   input wire logic [31:0]                RDATA,
   input wire logic                       MOVE_START,
   input wire logic [mps_pkg::SET_W-1:0]  CUR_SET,
   input wire logic                       PROG_RUN,
   input wire logic                       JOG_POS,
   input wire logic                       JOG_NEG
);
   import mps_pkg::*;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (RESET);
   logic jog_en_r;
   // jog may lag a disabling write, so the past terms below allow two cycles
   always_ff @(posedge CORE_CLK) begin
      if (RESET)
         jog_en_r <= 1'b0;
      else if (WR && ADDR == REG_CTRL)
         jog_en_r <= WDATA[CTRL_JOG_EN];
   end
   sequence s_wr_entry;
      WR && ADDR == REG_ENTRY;
   endsequence
   sequence s_rd_entry;
      RD && ADDR == REG_ENTRY;
   endsequence
   sequence s_go;
      WR && ADDR == REG_START && !PROG_RUN;
   endsequence
   property p_entry;
      s_wr_entry ##2 s_rd_entry |=> RDATA[15:0] == $past(WDATA[15:0], 3);
   endproperty
   a_entry: assert property (p_entry) else $error("entry readback differs");
   property p_go;
      s_go |-> ##3 MOVE_START && CUR_SET == $past(WDATA[7:0], 3);
   endproperty
   a_go: assert property (p_go) else $error("direct start not taken");
   property p_hold;
      !MOVE_START |-> $stable(CUR_SET);
   endproperty
   a_hold: assert property (p_hold) else $error("set changed without start");
   property p_run;
      MOVE_START |-> PROG_RUN;
   endproperty
   a_run: assert property (p_run) else $error("start outside run state");
   property p_pulse;
      MOVE_START |=> !MOVE_START;
   endproperty
   a_pulse: assert property (p_pulse) else $error("start pulse too long");
   property p_jog_dir;
      !(JOG_POS && JOG_NEG);
   endproperty
   a_jog_dir: assert property (p_jog_dir) else $error("both jog directions");
   property p_jog_en;
      JOG_POS || JOG_NEG |-> jog_en_r || $past(jog_en_r) || $past(jog_en_r, 2);
   endproperty
   a_jog_en: assert property (p_jog_en) else $error("jog while disabled");
   property p_quiet;
      !$past(RD) |-> RDATA == 32'h0;
   endproperty
   a_quiet: assert property (p_quiet) else $error("read data outside slot");
endmodule // mps_seq_checker

bind mps_sequencer mps_seq_checker u_chk (.*);

// file: bench/motion_core_model.sv
// far-side stand-in: motion core reporting target reached after a set delay
`timescale 1ns/1ps
module motion_core_model (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  dly,
   input wire logic        start,
   input wire logic [31:0] target,
   output logic            done,
   output logic [31:0]     act_pos,
   output logic [31:0]     sp_pos
);
   logic [7:0] cnt_r;
   always_ff @(posedge clk) begin
      if (rst || start) begin
         cnt_r <= 8'h00;
         done  <= 1'b0;
      end else if (cnt_r == dly)
         done <= 1'b1;
      else
         cnt_r <= cnt_r + 8'h01;
   end
   // positions differ from target while moving, so no compare passes by luck
   assign act_pos = done ? target : ~target;
   assign sp_pos  = done ? target : target ^ 32'h0000_00ff;
endmodule // motion_core_model

// file: bench/mps_sequencer_test.sv
// self-checking bench for the motion program sequencer
`timescale 1ns/1ps
module mps_sequencer_test;
   import mps_pkg::*;
   logic        CORE_CLK = 1'b0;
   logic        RESET = 1'b1;
   logic [11:0] ADDR = 12'h000;
   logic [31:0] WDATA = 32'h0;
   logic        WR = 1'b0;
   logic        RD = 1'b0;
   logic [7:0]  DIN = 8'h00;
   logic [7:0]  dly = 8'h04;
   logic [31:0] RDATA, MOVE_TARGET, ACT_POS, SP_POS;
   logic [15:0] JOG_SPEED, JOG_ACCEL;
   logic [7:0]  CUR_SET;
   logic [1:0]  DOUT;
   logic        TARGET_DONE, MOVE_START, PROG_RUN, JOG_POS, JOG_NEG;
   int          n_mismatch = 0;
   int          n_checks = 0;
   always #2 CORE_CLK = ~CORE_CLK;
   mps_sequencer dut (.*);
   motion_core_model core (.clk(CORE_CLK), .rst(RESET), .dly(dly), .start(MOVE_START),
      .target(MOVE_TARGET), .done(TARGET_DONE), .act_pos(ACT_POS), .sp_pos(SP_POS));
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge CORE_CLK);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CORE_CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      @(posedge CORE_CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CORE_CLK);
      RD <= 1'b0;
      #1 chk(RDATA, e);
   endtask
   task automatic pin(input logic [7:0] v);
      @(posedge CORE_CLK);
      DIN <= v;
   endtask
   // sets are written with ignore-stop clear unless or-ed in by the caller
   task automatic prog(input logic [7:0] s, s1, s2, input logic [3:0] r);
      wr(SET_CFG_BASE + {4'h0, s}, {12'h000, r, s2, s1});
   endtask
   task automatic wset(input logic [7:0] s);
      int i = 0;
      do begin
         cyc(1);
         i++;
      end while (MOVE_START !== 1'b1 && i < 300);
      if (MOVE_START !== 1'b1) begin
         n_mismatch++;
         print_verdict();
      end else
         chk(CUR_SET, s);
   endtask
   task automatic whalt;
      int i = 0;
      while (PROG_RUN !== 1'b0 && i < 300) begin
         cyc(1);
         i++;
      end
      chk(PROG_RUN, 0);
      if (PROG_RUN !== 1'b0)
         print_verdict();
   endtask
   task automatic t_regs;
      rd(REG_DINMAP, 32'h00fa_c21a);
      wr(REG_ENTRY, 32'h0000_1234);
      rd(REG_ENTRY, 32'h0000_1234);
      rd(12'h0ff, 32'h0);
   endtask
   task automatic t_now;
      dly <= 8'd60;
      prog(5, 6, 7, REACT_NOW);
      prog(6, 0, 0, REACT_FINAL);
      wr(REG_START, 32'h5);
      wset(5);
      pin(8'h04);
      wset(6);
      whalt();
      pin(8'h00);
   endtask
   task automatic t_ignore;
      dly <= 8'd2;
      prog(10, 11, 12, REACT_IGNORE);
      prog(11, 0, 0, REACT_FINAL);
      pin(8'h08);
      wr(REG_START, 32'ha);
      wset(10);
      wset(11);
      whalt();
      pin(8'h00);
   endtask
   task automatic t_latch;
      dly <= 8'd40;
      prog(20, 21, 22, REACT_LATCH);
      prog(22, 0, 0, REACT_FINAL);
      wr(REG_START, 32'h14);
      wset(20);
      pin(8'h04);
      pin(8'h00);
      pin(8'h08);
      wset(22);
      whalt();
      pin(8'h00);
   endtask
   task automatic t_both;
      dly <= 8'd20;
      prog(23, 24, 25, REACT_AT_TGT);
      prog(24, 0, 0, REACT_FINAL);
      pin(8'h0c);
      wr(REG_START, 32'h17);
      wset(23);
      wset(24);
      whalt();
      pin(8'h00);
   endtask
   task automatic t_entry;
      dly <= 8'd20;
      prog(8'h34, 8'h34, 8'h34, REACT_IGNORE);
      prog(8'h12, 8'h00, 8'h00, REACT_FINAL);
      pin(8'h02);
      wset(8'h12);
      whalt();
      pin(8'h20);
      pin(8'h00);
      wset(8'h34);
      pin(8'h20);
      pin(8'h00);
      whalt();
      pin(8'h01);
      wset(8'h34);
      pin(8'h20);
      pin(8'h00);
      whalt();
   endtask
   task automatic t_stop;
      dly <= 8'd20;
      prog(30, 30, 30, REACT_IGNORE);
      wr(SET_CFG_BASE + 12'd31, 32'h0009_1e1e);
      wr(REG_START, 32'h1f);
      wset(31);
      pin(8'h10);
      pin(8'h00);
      wset(30);
      cyc(2);
      chk(PROG_RUN, 1);
      whalt();
      pin(8'h10);
      wr(REG_START, 32'h1e);
      wset(30);
      cyc(3);
      chk(PROG_RUN, 0);
      pin(8'h00);
      cyc(20);
      chk(PROG_RUN, 0);
   endtask
   task automatic t_single;
      dly <= 8'd3;
      wr(REG_CTRL, 32'h0);
      wr(SET_TGT_BASE + 12'd40, 32'h0000_1000);
      prog(40, 41, 41, REACT_IGNORE);
      wr(REG_START, 32'h28);
      wset(40);
      chk(MOVE_TARGET, 32'h0000_1000);
      whalt();
      cyc(10);
      chk(CUR_SET, 8'd40);
      wr(REG_CTRL, 32'h1);
   endtask
   task automatic t_dout;
      wr(REG_TOL, 32'h0);
      wr(REG_DOUTSEL, 32'h0000_000b);
      wr(REG_CTRL, 32'h5);
      cyc(6);
      chk(DOUT, 2'b11);
      wr(REG_CTRL, 32'h1);
      wr(REG_DOUTSEL, 32'h0000_0003);
      cyc(6);
      chk(DOUT, 2'b10);
      wr(REG_TRIGPOS, 32'h0000_1000);
      wr(REG_DOUTSEL, 32'h0000_0020);
      cyc(6);
      chk(DOUT, 2'b11);
      wr(SET_REM_BASE + 12'd40, 32'hffff_e000);
      wr(SET_CFG_BASE + 12'd40, 32'h0021_2929);
      wr(REG_DOUTSEL, 32'h0000_0015);
      wr(REG_CTRL, 32'h0);
      dly <= 8'd60;
      wr(REG_START, 32'h28);
      wset(40);
      cyc(3);
      chk(DOUT[0], 1);
      chk(DOUT[1], 1);
      whalt();
      cyc(1);
      chk(DOUT, 2'b00);
      wr(REG_CTRL, 32'h1);
   endtask
   task automatic t_jog;
      wr(REG_JOGSPD, 32'h0003_0002);
      wr(REG_JOGACC, 32'h0005_0004);
      pin(8'h40);
      cyc(8);
      chk(JOG_POS, 0);
      wr(REG_CTRL, 32'h3);
      cyc(8);
      chk({JOG_POS, JOG_NEG}, 2'b10);
      chk({JOG_SPEED, JOG_ACCEL}, 32'h0002_0004);
      pin(8'h80);
      cyc(8);
      chk({JOG_POS, JOG_NEG}, 2'b01);
      chk({JOG_SPEED, JOG_ACCEL}, 32'h0003_0005);
      pin(8'h00);
      cyc(8);
      chk({JOG_POS, JOG_NEG}, 2'b00);
      wr(REG_CTRL, 32'h1);
   endtask
   initial begin
      repeat (2) @(posedge CORE_CLK);
      RESET <= 1'b0;
      t_regs();
      wr(REG_CTRL, 32'h1);
      t_now();
      t_ignore();
      t_latch();
      t_both();
      t_entry();
      t_stop();
      t_single();
      t_dout();
      t_jog();
      print_verdict();
   end
endmodule // mps_sequencer_test
